//--- port_ingress_priority_auth_control.v
// per-port ingress priority, tag discard and authentication control
`timescale 1ns/100ps
`include "port_ingress_defines.vh"

module port_ingress_priority_auth_control #(
    parameter NPORT = 7
) (
    input  wire                 clk,
    input  wire                 rst_n,
    // classic wishbone slave
    input  wire                 wb_cyc_i,
    input  wire                 wb_stb_i,
    input  wire                 wb_we_i,
    input  wire [16:0]          wb_adr_i,
    input  wire [3:0]           wb_sel_i,
    input  wire [31:0]          wb_dat_i,
    output reg  [31:0]          wb_dat_o,
    output reg                  wb_ack_o,
    // acl filtering enabled per port, from the acl engine
    input  wire [NPORT-1:0]     acl_enabled,
    // packet under classification
    input  wire                 pkt_valid,
    input  wire [2:0]           pkt_port,
    input  wire                 pkt_tagged,
    input  wire [2:0]           pkt_user_prio,
    input  wire [2:0]           pkt_default_prio,
    input  wire                 mac_hit,
    input  wire [2:0]           mac_prio,
    input  wire                 vlan_hit,
    input  wire [2:0]           vlan_prio,
    input  wire                 dsv_hit,
    input  wire [2:0]           dsv_prio,
    input  wire                 acl_hit,
    input  wire [2:0]           acl_prio,
    input  wire                 acl_drop,
    // classification result
    output reg                  res_valid,
    output reg  [2:0]           res_prio,
    output reg  [2:0]           res_user_prio,
    output reg                  res_discard,
    output reg                  res_to_host,
    // indirect selectors of every port, port p at [3p+:3] and [2p+:2]
    output reg  [3*NPORT-1:0]   ptr_port_idx,
    output reg  [2*NPORT-1:0]   ptr_queue
);

    // controls of all ports side by side
    wire [8*NPORT-1:0]  src_all;
    wire [8*NPORT-1:0]  tag_all;
    wire [2*NPORT-1:0]  mode_all;

    // address decode: port number in the upper bits, index below
    wire [2:0]  bus_port = wb_adr_i[16:14];
    wire [11:0] bus_idx  = wb_adr_i[13:2];
    wire        bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire        port_ok  = (bus_port != 3'h0) && (bus_port <= NPORT);
    // writes land on the edge at which the master sees ack high
    wire        wr_take  = wb_cyc_i & wb_stb_i & wb_ack_o
                         & wb_we_i & port_ok;

    // reset images of the narrow fields, cut from the full words
    wire [7:0]  auth_rst = `RST_AUTH_CTRL & `MASK_AUTH_CTRL;
    wire [31:0] qptr_rst = `RST_QPTR;

    // one bank of controls per port
    genvar p;
    generate
        for (p = 0; p < NPORT; p = p + 1)
        begin : gen_port
            // control storage of this port
            reg [7:0] src_sel_reg;
            reg [7:0] tag_ctrl_reg;
            reg [1:0] auth_mode_reg;
            reg [2:0] pidx_reg;
            reg [1:0] qptr_reg;
            wire      hit = wr_take && (bus_port == p + 1);

            // write strobes of this port's registers
            wire      wr_src  = hit & bus_idx == `IDX_SRC_SEL & wb_sel_i[0];
            wire      wr_tag  = hit & bus_idx == `IDX_TAG_CTRL & wb_sel_i[0];
            wire      wr_auth = hit & bus_idx == `IDX_AUTH_CTRL & wb_sel_i[0];
            wire      wr_pidx = hit & bus_idx == `IDX_QPTR & wb_sel_i[2];
            wire      wr_q    = hit & bus_idx == `IDX_QPTR & wb_sel_i[0];

            // register writes, byte lane 0 for 8-bit registers
            always @(posedge clk)
            begin
                if (!rst_n)
                begin
                    src_sel_reg   <= `RST_SRC_SEL;
                    tag_ctrl_reg  <= `RST_TAG_CTRL;
                    auth_mode_reg <= auth_rst[1:0];
                    pidx_reg      <= qptr_rst[`PTR_PORT_HI:`PTR_PORT_LO];
                    qptr_reg      <= qptr_rst[`PTR_Q_HI:`PTR_Q_LO];
                end
                else if (hit)
                begin
                    if (wr_src)
                        src_sel_reg <= wb_dat_i[7:0] & `MASK_SRC_SEL;
                    if (wr_tag)
                        tag_ctrl_reg <= wb_dat_i[7:0] & `MASK_TAG_CTRL;
                    if (wr_auth)
                        auth_mode_reg <= wb_dat_i[1:0];
                    // pointer halves follow their own byte lanes
                    if (wr_pidx)
                        pidx_reg <= wb_dat_i[`PTR_PORT_HI:`PTR_PORT_LO];
                    if (wr_q)
                        qptr_reg <= wb_dat_i[`PTR_Q_HI:`PTR_Q_LO];
                end
            end

            // flatten for the shared read and packet muxes
            assign src_all[8*p+:8]  = src_sel_reg;
            assign tag_all[8*p+:8]  = tag_ctrl_reg;
            assign mode_all[2*p+:2] = auth_mode_reg;

            // pointer fields out to the indirect tables
            always @(posedge clk)
            begin
                if (!rst_n)
                begin
                    ptr_port_idx[3*p+:3] <= 3'h0;
                    ptr_queue[2*p+:2]    <= 2'h0;
                end
                else
                begin
                    ptr_port_idx[3*p+:3] <= pidx_reg;
                    ptr_queue[2*p+:2]    <= qptr_reg;
                end
            end
        end
    endgenerate

    // read data of the addressed register, zero for unmapped
    reg [31:0] rd_data;
    reg [2:0]  bp;
    always @*
    begin
        rd_data = 32'h00000000;
        bp = bus_port - 3'h1;
        // only ports 1 to NPORT answer with data
        if (port_ok)
        begin
            case (bus_idx)
                `IDX_SRC_SEL:
                    rd_data[7:0] = src_all[8*bp+:8];
                `IDX_TAG_CTRL:
                    rd_data[7:0] = tag_all[8*bp+:8];
                `IDX_AUTH_CTRL:
                begin
                    rd_data[`AC_ACL_EN] = acl_enabled[bp];
                    rd_data[1:0] = mode_all[2*bp+:2];
                end
                `IDX_QPTR:
                begin
                    rd_data[`PTR_PORT_HI:`PTR_PORT_LO] =
                        gen_sel_pidx(ptr_port_idx, bp);
                    rd_data[`PTR_Q_HI:`PTR_Q_LO] = gen_sel_q(ptr_queue, bp);
                end
                default:
                    rd_data = 32'h00000000;
            endcase
        end
    end

    // pointer read helpers over the registered pointer outputs
    function [2:0] gen_sel_pidx;
        input [3*NPORT-1:0] v;
        input [2:0]         idx;
        begin
            gen_sel_pidx = v[3*idx+:3];
        end
    endfunction

    function [1:0] gen_sel_q;
        input [2*NPORT-1:0] v;
        input [2:0]         idx;
        begin
            gen_sel_q = v[2*idx+:2];
        end
    endfunction

    // bus answer one cycle after the request, dropped the next cycle
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : 32'h00000000;
        end
    end

    // controls of the packet's port
    reg [7:0] ss;
    reg [7:0] tc;
    reg [1:0] am;
    reg       acl_on;
    reg [2:0] pp;
    always @*
    begin
        pp = pkt_port - 3'h1;
        ss = 8'h00;
        tc = 8'h00;
        am = 2'h0;
        acl_on = 1'b0;
        // out-of-range port sees all controls at zero
        if (pkt_port != 3'h0 && pkt_port <= NPORT)
        begin
            ss = src_all[8*pp+:8];
            tc = tag_all[8*pp+:8];
            am = mode_all[2*pp+:2];
            acl_on = acl_enabled[pp];
        end
    end

    // enabled classifier hits
    wire h_mac  = ss[`SS_MAC] & mac_hit;
    wire h_vlan = ss[`SS_VLAN] & vlan_hit;
    wire h_1p   = ss[`SS_DOT1P] & pkt_tagged;
    wire h_dsv  = ss[`SS_DSV] & dsv_hit;
    wire h_acl  = ss[`SS_ACL] & acl_hit;

    // masked priorities of the enabled hits
    wire [2:0] m_mac  = {3{h_mac}} & mac_prio;
    wire [2:0] m_vlan = {3{h_vlan}} & vlan_prio;
    wire [2:0] m_1p   = {3{h_1p}} & pkt_user_prio;
    wire [2:0] m_dsv  = {3{h_dsv}} & dsv_prio;
    wire [2:0] m_acl  = {3{h_acl}} & acl_prio;

    // combine the priority results
    reg [2:0] prio;
    reg       any;
    always @*
    begin
        any  = h_mac | h_vlan | h_1p | h_dsv | h_acl;
        prio = 3'h0;
        if (ss[`SS_HIGHEST])
        begin
            if (h_mac && mac_prio > prio) prio = mac_prio;
            if (h_vlan && vlan_prio > prio) prio = vlan_prio;
            if (h_1p && pkt_user_prio > prio) prio = pkt_user_prio;
            if (h_dsv && dsv_prio > prio) prio = dsv_prio;
            if (h_acl && acl_prio > prio) prio = acl_prio;
        end
        else if (ss[`SS_ORED])
        begin
            prio = m_mac | m_vlan | m_1p | m_dsv | m_acl;
        end
        // neither mode bit: fixed precedence, acl first
        else if (h_acl)
            prio = acl_prio;
        else if (h_dsv)
            prio = dsv_prio;
        else if (h_1p)
            prio = pkt_user_prio;
        else if (h_vlan)
            prio = vlan_prio;
        else if (h_mac)
            prio = mac_prio;
        // no enabled classifier hit: port default
        if (!any)
            prio = tc[`TC_DEF_HI:`TC_DEF_LO];
    end

    // forwarding decision from tag discard and authentication mode
    reg drop;
    reg to_host;
    always @*
    begin
        drop = (tc[`TC_DROP_UNTAG] & ~pkt_tagged)
             | (tc[`TC_DROP_TAG] & pkt_tagged);
        to_host = 1'b0;
        // authentication mode on top of tag discard
        case (am)
            `AUTH_BLOCK:
                drop = drop | (acl_on ? ~acl_hit : acl_drop);
            `AUTH_PASS:
                drop = drop | (~acl_on & acl_drop);
            `AUTH_TRAP:
            begin
                to_host = 1'b1;
                drop = drop | (acl_on ? ~acl_hit : acl_drop);
            end
            default:
                drop = drop;
        endcase
    end

    // user priority ceiling against the port default tag
    reg [2:0] user_prio;
    always @*
    begin
        user_prio = pkt_user_prio;
        if (tc[`TC_CEIL] && pkt_user_prio > pkt_default_prio)
            user_prio = pkt_default_prio;
    end

    // registered result, one cycle after the packet
    always @(posedge clk)
    begin
        if (!rst_n)
        begin
            res_valid     <= 1'b0;
            res_prio      <= 3'h0;
            res_user_prio <= 3'h0;
            res_discard   <= 1'b0;
            res_to_host   <= 1'b0;
        end
        else
        begin
            res_valid   <= pkt_valid;
            res_prio    <= prio;
            res_discard <= drop;
            res_to_host <= to_host & ~drop;
            res_user_prio <= user_prio;
        end
    end

endmodule // port_ingress_priority_auth_control

//--- port_ingress_defines.vh
// constants for the per-port ingress priority and authentication registers
`ifndef PORT_INGRESS_DEFINES_VH
`define PORT_INGRESS_DEFINES_VH

// register indexes within a port page, byte address is four times these
`define IDX_SRC_SEL      12'h801
`define IDX_TAG_CTRL     12'h802
`define IDX_AUTH_CTRL    12'h803
`define IDX_QPTR         12'h804

// reset values
`define RST_SRC_SEL      8'h00
`define RST_TAG_CTRL     8'h00
`define RST_AUTH_CTRL    8'h00
`define RST_QPTR         32'h00000000

// writable masks, all other bits read zero except the acl enable bit read back in auth control
`define MASK_SRC_SEL     8'hdf
`define MASK_TAG_CTRL    8'h9f
`define MASK_AUTH_CTRL   8'h03

// source select fields
`define SS_HIGHEST       7
`define SS_ORED          6
`define SS_MAC           4
`define SS_VLAN          3
`define SS_DOT1P         2
`define SS_DSV           1
`define SS_ACL           0

// tag control fields
`define TC_CEIL          7
`define TC_DROP_UNTAG    4
`define TC_DROP_TAG      3
`define TC_DEF_HI        2
`define TC_DEF_LO        0

// authentication control fields and modes
`define AC_ACL_EN        2
`define AUTH_RSVD        2'h0
`define AUTH_BLOCK       2'h1
`define AUTH_PASS        2'h2
`define AUTH_TRAP        2'h3

// pointer fields
`define PTR_PORT_HI      18
`define PTR_PORT_LO      16
`define PTR_Q_HI         1
`define PTR_Q_LO         0

`endif

//--- port_ingress_checker.sv
// port-level assertions for the ingress priority and auth block
`timescale 1ns/100ps
module port_ingress_checker #(
    parameter NPORT = 7
) (
    input wire               clk,
    input wire               rst_n,
    input wire               wb_cyc_i,
    input wire               wb_stb_i,
    input wire               wb_we_i,
    input wire [31:0]        wb_dat_o,
    input wire               wb_ack_o,
    input wire               pkt_valid,
    input wire [2:0]         pkt_user_prio,
    input wire [2:0]         pkt_default_prio,
    input wire               res_valid,
    input wire [2:0]         res_user_prio,
    input wire               res_discard,
    input wire               res_to_host,
    input wire [3*NPORT-1:0] ptr_port_idx,
    input wire [2*NPORT-1:0] ptr_queue
);
    reg wr_d1_reg;
    reg wr_d2_reg;
    // delayed write acks, pointer outputs may only move after one
    always @(posedge clk)
    begin
        wr_d1_reg <= rst_n && wb_ack_o && wb_we_i;
        wr_d2_reg <= rst_n && wr_d1_reg;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // bus request taken, then a single ack pulse
    sequence s_take;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_pulse;
        wb_ack_o ##1 !wb_ack_o;
    endsequence
    chk_ack_one_pulse: assert property (s_take |=> s_pulse)
        else $error("ack not a pulse one cycle after request");
    chk_ack_has_cause: assert property
        (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i))
        else $error("ack without request");
    chk_dat_idle_zero: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    chk_res_follows_pkt: assert property
        (1'b1 |=> res_valid == $past(pkt_valid))
        else $error("result valid not one cycle after packet");
    chk_user_prio_src: assert property (pkt_valid |=>
        res_user_prio == $past(pkt_user_prio) ||
        (res_user_prio == $past(pkt_default_prio) &&
         $past(pkt_user_prio) > $past(pkt_default_prio)))
        else $error("user priority from no source");
    chk_host_not_dropped: assert property (res_to_host |-> !res_discard)
        else $error("host copy of a discarded packet");
    chk_port_idx_write: assert property
        ($changed(ptr_port_idx) |-> wr_d1_reg || wr_d2_reg)
        else $error("port index moved without write");
    chk_queue_ptr_write: assert property
        ($changed(ptr_queue) |-> wr_d1_reg || wr_d2_reg)
        else $error("queue pointer moved without write");
endmodule // port_ingress_checker

//--- port_ingress_priority_auth_control_tb_top.sv
// self-checking bench for the ingress priority and auth block
`timescale 1ns/100ps
`include "port_ingress_defines.vh"
module port_ingress_priority_auth_control_tb_top;
    reg         clk;
    reg         rst_n;
    reg         cyc;
    reg         we;
    reg  [16:0] adr;
    reg  [31:0] wdat;
    wire [31:0] rdat;
    wire        ack;
    reg  [6:0]  acl_en;
    reg         pv;
    reg         tg;
    reg         drop;
    reg  [3:0]  hit;
    reg  [11:0] cp;
    reg  [2:0]  upr;
    reg  [2:0]  dpr;
    reg  [3:0]  sel;
    reg  [2:0]  pport;
    wire        rv;
    wire [2:0]  rp;
    wire [2:0]  rup;
    wire        rd;
    wire        rh;
    wire [20:0] pidx;
    wire [13:0] pq;
    reg  [31:0] rv32;
    reg  [14:0] tbl;
    integer     err_count;
    integer     checks_done;
    integer     i;

    // block under test
    port_ingress_priority_auth_control #(.NPORT(7))
        u_port_ingress_priority_auth_control (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
        .wb_dat_o(rdat), .wb_ack_o(ack), .acl_enabled(acl_en),
        .pkt_valid(pv), .pkt_port(pport), .pkt_tagged(tg),
        .pkt_user_prio(upr), .pkt_default_prio(dpr),
        .mac_hit(hit[3]), .mac_prio(cp[2:0]), .vlan_hit(hit[2]),
        .vlan_prio(cp[5:3]), .dsv_hit(hit[1]), .dsv_prio(cp[8:6]),
        .acl_hit(hit[0]), .acl_prio(cp[11:9]), .acl_drop(drop),
        .res_valid(rv), .res_prio(rp), .res_user_prio(rup),
        .res_discard(rd), .res_to_host(rh), .ptr_port_idx(pidx),
        .ptr_queue(pq));

    // clock, 50 ns period
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task test_done;
    begin
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    end
    endtask

    // one classic wishbone cycle, held until ack
    task acc(input [2:0] n, input [11:0] x, input w, input [31:0] d);
    begin
        @(posedge clk);
        cyc  <= 1'b1;
        we   <= w;
        adr  <= {n, x, 2'b00};
        wdat <= d;
        @(posedge clk);
        while (ack !== 1'b1)
            @(posedge clk);
        rv32 = rdat;
        cyc <= 1'b0;
    end
    endtask

    task rdc(input [2:0] n, input [11:0] x, input [31:0] e);
    begin
        acc(n, x, 1'b0, 32'h0);
        chk(rv32, e);
    end
    endtask

    // one packet, result {prio, user prio, discard, host}
    task pk(input t, input [3:0] h, input [7:0] e);
    begin
        @(posedge clk);
        pv  <= 1'b1;
        tg  <= t;
        hit <= h;
        @(posedge clk);
        pv <= 1'b0;
        @(negedge clk);
        chk({24'h0, rp, rup, rd, rh}, {24'h0, e});
        @(posedge clk);
    end
    endtask

    // watchdog
    initial
    begin
        #100000;
        err_count = err_count + 1;
        test_done;
    end

    // main sequence
    initial
    begin
        rst_n = 1'b0; cyc = 1'b0; we = 1'b0; adr = 17'h0; wdat = 32'h0;
        acl_en = 7'h0; pv = 1'b0; tg = 1'b0; drop = 1'b0; hit = 4'h0;
        cp = {3'h3, 3'h4, 3'h2, 3'h1}; upr = 3'h5; dpr = 3'h2;
        sel = 4'hf;
        pport = 3'h1;
        tbl = {3'h1, 3'h2, 3'h5, 3'h4, 3'h3};
        err_count = 0; checks_done = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i = i + 1)
            rdc(3'h1, `IDX_SRC_SEL + i, 32'h0);
        acc(3'h1, `IDX_SRC_SEL, 1'b1, 32'hff);
        rdc(3'h1, `IDX_SRC_SEL, 32'hdf);
        acc(3'h1, `IDX_TAG_CTRL, 1'b1, 32'hff);
        rdc(3'h1, `IDX_TAG_CTRL, 32'h9f);
        acc(3'h1, `IDX_AUTH_CTRL, 1'b1, 32'hff);
        rdc(3'h1, `IDX_AUTH_CTRL, 32'h03);
        acl_en <= 7'h01;
        rdc(3'h1, `IDX_AUTH_CTRL, 32'h07);
        acc(3'h1, `IDX_QPTR, 1'b1, 32'hffffffff);
        rdc(3'h1, `IDX_QPTR, 32'h00070003);
        acc(3'h3, `IDX_QPTR, 1'b1, 32'h00050002);
        rdc(3'h3, `IDX_QPTR, 32'h00050002);
        chk({11'h0, pidx}, 32'h147);
        chk({18'h0, pq}, 32'h23);
        sel <= 4'h1;
        acc(3'h3, `IDX_QPTR, 1'b1, 32'h00070001);
        sel <= 4'hf;
        rdc(3'h3, `IDX_QPTR, 32'h00050001);
        acc(3'h1, 12'h805, 1'b1, 32'hff);
        rdc(3'h1, 12'h805, 32'h0);
        rdc(3'h0, `IDX_SRC_SEL, 32'h0);
        $display("test registers done");
        acc(3'h1, `IDX_TAG_CTRL, 1'b1, 32'h06);
        acc(3'h1, `IDX_AUTH_CTRL, 1'b1, 32'h0);
        for (i = 0; i < 5; i = i + 1)
        begin
            acc(3'h1, `IDX_SRC_SEL, 1'b1, 32'h1 << i);
            pk(1'b1, 4'hf, {tbl[3*i +: 3], 5'h14});
        end
        acc(3'h1, `IDX_SRC_SEL, 1'b1, 32'h01);
        pk(1'b1, 4'h8, {3'h6, 5'h14});
        acc(3'h1, `IDX_SRC_SEL, 1'b1, 32'h8b);
        pk(1'b1, 4'hf, {3'h4, 5'h14});
        acc(3'h1, `IDX_SRC_SEL, 1'b1, 32'h4b);
        pk(1'b1, 4'hf, {3'h7, 5'h14});
        acc(3'h1, `IDX_SRC_SEL, 1'b1, 32'h00);
        pk(1'b1, 4'hf, {3'h6, 5'h14});
        $display("test classify done");
        acc(3'h1, `IDX_TAG_CTRL, 1'b1, 32'h86);
        pk(1'b1, 4'h0, {3'h6, 3'h2, 2'b00});
        acc(3'h1, `IDX_TAG_CTRL, 1'b1, 32'h16);
        pk(1'b0, 4'h0, {3'h6, 5'h16});
        pk(1'b1, 4'h0, {3'h6, 5'h14});
        acc(3'h1, `IDX_TAG_CTRL, 1'b1, 32'h0e);
        pk(1'b1, 4'h0, {3'h6, 5'h16});
        pk(1'b0, 4'h0, {3'h6, 5'h14});
        $display("test tag control done");
        acc(3'h1, `IDX_TAG_CTRL, 1'b1, 32'h06);
        acc(3'h1, `IDX_AUTH_CTRL, 1'b1, {30'h0, `AUTH_BLOCK});
        pk(1'b1, 4'h0, {3'h6, 5'h16});
        acc(3'h1, `IDX_AUTH_CTRL, 1'b1, {30'h0, `AUTH_PASS});
        pk(1'b1, 4'h0, {3'h6, 5'h14});
        acc(3'h1, `IDX_AUTH_CTRL, 1'b1, {30'h0, `AUTH_TRAP});
        pk(1'b1, 4'h0, {3'h6, 5'h16});
        pk(1'b1, 4'h1, {3'h6, 5'h15});
        acc(3'h1, `IDX_AUTH_CTRL, 1'b1, {30'h0, `AUTH_RSVD});
        pk(1'b1, 4'h0, {3'h6, 5'h14});
        acl_en <= 7'h00;
        drop <= 1'b1;
        acc(3'h1, `IDX_AUTH_CTRL, 1'b1, {30'h0, `AUTH_PASS});
        pk(1'b1, 4'h0, {3'h6, 5'h16});
        drop <= 1'b0;
        acc(3'h1, `IDX_AUTH_CTRL, 1'b1, {30'h0, `AUTH_BLOCK});
        pk(1'b1, 4'h0, {3'h6, 5'h14});
        pport <= 3'h3;
        pk(1'b1, 4'h0, {3'h0, 5'h14});
        $display("test authentication done");
        test_done;
    end
endmodule // port_ingress_priority_auth_control_tb_top

bind port_ingress_priority_auth_control port_ingress_checker #(
    .NPORT(NPORT)) u_port_ingress_checker (
    .clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .pkt_valid(pkt_valid), .pkt_user_prio(pkt_user_prio),
    .pkt_default_prio(pkt_default_prio), .res_valid(res_valid),
    .res_user_prio(res_user_prio), .res_discard(res_discard),
    .res_to_host(res_to_host), .ptr_port_idx(ptr_port_idx),
    .ptr_queue(ptr_queue));
